//--- design/fmmp_pkg.sv
package fmmp_pkg;

	localparam logic [6:0]  I2C_ADDR       = 7'h2E;
	localparam logic [15:0] CMD_STOP       = 16'h3FF9;
	localparam logic [15:0] CMD_UPD_CONC   = 16'hE17D;
	localparam logic [15:0] CMD_SOFT_RESET = 16'h0006;
	localparam logic [15:0] START_CODES [9] = '{16'h3603, 16'h3608, 16'h3615, 16'h361E,
		16'h3624, 16'h362F, 16'h3632, 16'h3639, 16'h3646};
	localparam logic [3:0]  FIRST_MIX_IDX  = 4'h6;
	localparam logic [9:0]  CONC_PURE      = 10'h3FF;
	localparam logic [15:0] CONC_MAX       = 16'h03E8;
	localparam logic [7:0]  CRC_POLY       = 8'h31;
	localparam logic [7:0]  CRC_INIT       = 8'hFF;

	localparam int ST_CODE_LSB   = 12;
	localparam int ST_SMOOTH_BIT = 11;
	localparam int ST_AVG_BIT    = 10;
	localparam int CTRL_FIXED_BIT = 0;

	localparam logic [31:0] REG_CTRL     = 32'h0000_0000;
	localparam logic [31:0] REG_RESULT   = 32'h0000_0004;
	localparam logic [31:0] REG_STATUS   = 32'h0000_0008;
	localparam logic [31:0] REG_LAST_CMD = 32'h0000_000C;

	localparam longint CLK_HZ       = 50000000;
	localparam longint T_FIRST_MS   = 12;
	localparam longint T_SMOOTH_MS  = 64;
	localparam longint T_STOP_US    = 500;
	// Least times round up, the stop bound rounds down
	localparam int unsigned FIRST_CYC  = int'((T_FIRST_MS * CLK_HZ + 999) / 1000);
	localparam int unsigned SMOOTH_CYC = int'((T_SMOOTH_MS * CLK_HZ + 999) / 1000);
	localparam int unsigned STOP_CYC   = int'((T_STOP_US * CLK_HZ) / 1000000);

	typedef struct packed {
		logic        hsel;
		logic [31:0] haddr;
		logic [1:0]  htrans;
		logic        hwrite;
		logic [2:0]  hsize;
		logic [31:0] hwdata;
	} fmmp_ahb_req_t;

	typedef struct packed {
		logic [31:0] hrdata;
		logic        hreadyout;
		logic        hresp;
	} fmmp_ahb_rsp_t;

	function automatic logic [7:0] fmmp_crc8(input logic [15:0] d);
		logic [7:0] c;
		c = CRC_INIT;
		for (int i = 15; i >= 0; i--) begin
			c = (c[7] ^ d[i]) ? ({c[6:0], 1'b0} ^ CRC_POLY) : {c[6:0], 1'b0};
		end
		return c;
	endfunction

	// Returns {hit, table index}
	function automatic logic [4:0] fmmp_start_decode(input logic [15:0] c);
		logic [4:0] r;
		r = 5'h00;
		for (int i = 0; i < 9; i++) begin
			if (c == START_CODES[i]) begin
				r = {1'b1, 4'(i)};
			end
		end
		return r;
	endfunction

	function automatic logic fmmp_needs_arg(input logic [15:0] c);
		logic [4:0] s;
		s = fmmp_start_decode(c);
		return (c == CMD_UPD_CONC) || (s[4] && (s[3:0] >= FIRST_MIX_IDX));
	endfunction

endpackage

//--- design/fmmp_top.sv
// Chosen here: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ns
module fmmp_top #(
	parameter int unsigned FIRST_CYCLES  = fmmp_pkg::FIRST_CYC,
	parameter int unsigned SMOOTH_CYCLES = fmmp_pkg::SMOOTH_CYC,
	parameter int unsigned STOP_CYCLES   = fmmp_pkg::STOP_CYC
)(
	input  wire logic                    i_clk,
	input  wire logic                    i_srst,
	input  wire fmmp_pkg::fmmp_ahb_req_t i_ahb,
	input  wire logic                    i_hready,
	output fmmp_pkg::fmmp_ahb_rsp_t      o_ahb,
	input  wire logic                    i_scl,
	input  wire logic                    i_sda,
	output logic                         o_sda,
	output logic                         o_sda_oe_n
);
	import fmmp_pkg::*;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_RX   = 3'b001,
		ST_RACK = 3'b010,
		ST_TX   = 3'b011,
		ST_TACK = 3'b100
	} fmmp_state_t;

	fmmp_state_t state;
	logic        scl_q;
	logic        sda_q;
	logic [3:0]  bitcnt;
	logic [7:0]  shreg;
	logic        drive;
	logic        is_addr;
	logic        rd;
	logic [2:0]  wr_idx;
	logic [3:0]  rd_idx;
	logic [15:0] cmd;
	logic [15:0] arg;
	logic [15:0] snap_flow;
	logic [15:0] snap_temp;
	logic [15:0] snap_stat;
	logic        running;
	logic [3:0]  run_code;
	logic [9:0]  conc;
	logic        data_valid;
	logic        stop_busy;
	logic [31:0] warm_cnt;
	logic [31:0] stop_cnt;
	logic [31:0] smooth_cnt;
	logic        smoothed;
	logic        avg_fixed;
	logic [15:0] flow_buf;
	logic [15:0] temp_buf;
	logic        ph_wr;
	logic        ph_rd;
	logic        rd_out;
	logic [31:0] ph_addr;
	logic [31:0] hrdata;
	logic [15:0] stat_word;

	////////////////////////////////////////////////////////////////////////////////
	// Line events; inputs are already synchronous, so one previous sample suffices
	wire scl_rise  = i_scl & ~scl_q;
	wire scl_fall  = ~i_scl & scl_q;
	wire start_det = i_scl & scl_q & sda_q & ~i_sda;
	wire stop_det  = i_scl & scl_q & ~sda_q & i_sda;

	wire        byte_done = (state == ST_RX) && scl_fall && (bitcnt == 4'h8);
	wire        addr_hit  = (shreg[7:1] == I2C_ADDR);
	wire        rd_accept = byte_done && is_addr && addr_hit && shreg[0] && data_valid
		&& !stop_busy;
	wire        wr_accept = byte_done && is_addr && addr_hit && !shreg[0] && !stop_busy;
	wire [15:0] cmd_now   = {cmd[15:8], shreg};
	wire        arg_need  = fmmp_needs_arg(cmd);
	wire        crc_ok    = (fmmp_crc8(arg) == shreg);
	wire        data_ack  = (wr_idx < 3'h2) || ((wr_idx < 3'h4) && arg_need)
		|| ((wr_idx == 3'h4) && arg_need && crc_ok);
	wire        byte_ack  = is_addr ? (rd_accept | wr_accept) : data_ack;
	wire        fire_cmd  = byte_done && !is_addr && (wr_idx == 3'h1) && !fmmp_needs_arg(cmd_now);
	wire        fire_arg  = byte_done && !is_addr && (wr_idx == 3'h4) && arg_need && crc_ok;
	wire        exec      = fire_cmd | fire_arg;
	wire [15:0] exec_code = fire_cmd ? cmd_now : cmd;
	wire [4:0]  sdec      = fmmp_start_decode(exec_code);
	wire        soft_rst  = exec && (exec_code == CMD_SOFT_RESET);
	wire        do_start  = exec && sdec[4] && !running && !stop_busy;
	wire        conc_over = (arg > CONC_MAX);
	wire        do_stop   = exec && running && ((exec_code == CMD_STOP)
		|| ((exec_code == CMD_UPD_CONC) && conc_over));
	wire        do_upd    = exec && running && (exec_code == CMD_UPD_CONC) && !conc_over;

	// Byte selection for readout: three words, each trailed by its checksum
	wire [15:0] tx_word = (rd_idx < 4'h3) ? snap_flow : (rd_idx < 4'h6) ? snap_temp : snap_stat;
	wire [3:0]  tx_pos  = (rd_idx < 4'h3) ? rd_idx : (rd_idx < 4'h6) ? rd_idx - 4'h3
		: rd_idx - 4'h6;
	wire [7:0]  tx_byte = (rd_idx > 4'h8) ? 8'hFF : (tx_pos == 4'h0) ? tx_word[15:8]
		: (tx_pos == 4'h1) ? tx_word[7:0] : fmmp_crc8(tx_word);

	always_comb begin
		stat_word = {6'h00, conc};
		stat_word[ST_CODE_LSB +: 4] = run_code;
		stat_word[ST_SMOOTH_BIT] = smoothed;
		stat_word[ST_AVG_BIT] = avg_fixed;
	end

	assign o_sda      = 1'b0;
	assign o_sda_oe_n = ~drive;

	////////////////////////////////////////////////////////////////////////////////
	// Bit engine
	always_ff @(posedge i_clk) begin
		scl_q <= i_srst ? 1'b1 : i_scl;
		sda_q <= i_srst ? 1'b1 : i_sda;
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			state   <= ST_IDLE;
			bitcnt  <= 4'h0;
			shreg   <= 8'h00;
			drive   <= 1'b0;
			is_addr <= 1'b0;
			rd      <= 1'b0;
		end else if (start_det) begin
			state   <= ST_RX;
			bitcnt  <= 4'h0;
			is_addr <= 1'b1;
			drive   <= 1'b0;
		end else if (stop_det) begin
			state <= ST_IDLE;
			drive <= 1'b0;
		end else begin
			case (state)
				ST_RX: begin
					if (scl_rise) begin
						shreg  <= {shreg[6:0], i_sda};
						bitcnt <= bitcnt + 4'h1;
					end else if (byte_done) begin
						state <= byte_ack ? ST_RACK : ST_IDLE;
						drive <= byte_ack;
						if (is_addr) begin
							rd <= shreg[0];
						end
					end
				end
				ST_RACK: begin
					if (scl_fall) begin
						is_addr <= 1'b0;
						if (rd) begin
							state  <= ST_TX;
							drive  <= ~tx_byte[7];
							shreg  <= {tx_byte[6:0], 1'b0};
							bitcnt <= 4'h1;
						end else begin
							state  <= ST_RX;
							drive  <= 1'b0;
							bitcnt <= 4'h0;
						end
					end
				end
				ST_TX: begin
					if (scl_fall) begin
						if (bitcnt == 4'h8) begin
							state <= ST_TACK;
							drive <= 1'b0;
						end else begin
							drive  <= ~shreg[7];
							shreg  <= {shreg[6:0], 1'b0};
							bitcnt <= bitcnt + 4'h1;
						end
					end
				end
				ST_TACK: begin
					if (scl_rise && i_sda) begin
						state <= ST_IDLE;
					end else if (scl_fall) begin
						state  <= ST_TX;
						drive  <= ~tx_byte[7];
						shreg  <= {tx_byte[6:0], 1'b0};
						bitcnt <= 4'h1;
					end
				end
				default: begin
					drive <= 1'b0;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Transfer bookkeeping; snapshot keeps the three words coherent over one read
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			wr_idx    <= 3'h0;
			rd_idx    <= 4'h0;
			cmd       <= 16'h0000;
			arg       <= 16'h0000;
			snap_flow <= 16'h0000;
			snap_temp <= 16'h0000;
			snap_stat <= 16'h0000;
		end else begin
			if (start_det) begin
				wr_idx <= 3'h0;
			end else if (byte_done && byte_ack && !is_addr) begin
				case (wr_idx)
					3'h0: cmd[15:8] <= shreg;
					3'h1: cmd[7:0] <= shreg;
					3'h2: arg[15:8] <= shreg;
					3'h3: arg[7:0] <= shreg;
					default: cmd <= cmd;
				endcase
				wr_idx <= wr_idx + 3'h1;
			end
			if (rd_accept) begin
				snap_flow <= flow_buf;
				snap_temp <= temp_buf;
				snap_stat <= stat_word;
				rd_idx    <= 4'h0;
			end else if (state == ST_TACK && scl_rise && !i_sda && rd_idx != 4'hF) begin
				rd_idx <= rd_idx + 4'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Measurement mode
	always_ff @(posedge i_clk) begin
		if (i_srst || soft_rst) begin
			running    <= 1'b0;
			run_code   <= 4'h0;
			conc       <= CONC_PURE;
			data_valid <= 1'b0;
			warm_cnt   <= 32'h0;
			stop_busy  <= 1'b0;
			stop_cnt   <= 32'h0;
		end else if (do_start) begin
			running    <= 1'b1;
			run_code   <= sdec[3:0];
			conc       <= (sdec[3:0] >= FIRST_MIX_IDX) ? arg[9:0] : CONC_PURE;
			data_valid <= 1'b0;
			warm_cnt   <= 32'h0;
		end else if (do_stop) begin
			running    <= 1'b0;
			data_valid <= 1'b0;
			stop_busy  <= 1'b1;
			stop_cnt   <= 32'h0;
		end else begin
			if (do_upd) begin
				conc <= arg[9:0];
			end
			if (running && !data_valid) begin
				warm_cnt <= warm_cnt + 32'h1;
				if (warm_cnt == FIRST_CYCLES - 1) begin
					data_valid <= 1'b1;
				end
			end
			if (stop_busy) begin
				stop_cnt <= stop_cnt + 32'h1;
				if (stop_cnt == STOP_CYCLES - 1) begin
					stop_busy <= 1'b0;
				end
			end
		end
	end

	// A readout restarts the mean, so the timer only runs between readouts
	always_ff @(posedge i_clk) begin
		if (i_srst || soft_rst || !running || avg_fixed || rd_accept) begin
			smooth_cnt <= 32'h0;
			smoothed   <= 1'b0;
		end else if (data_valid && !smoothed) begin
			smooth_cnt <= smooth_cnt + 32'h1;
			if (smooth_cnt == SMOOTH_CYCLES - 1) begin
				smoothed <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// AHB-Lite slave: writes without wait, reads take one wait state
	wire        ahb_accept = i_ahb.hsel && i_ahb.htrans[1] && i_hready;
	wire        wr_now     = ph_wr && i_hready;
	wire [31:0] rd_mux     = (ph_addr == REG_CTRL) ? {31'h0, avg_fixed}
		: (ph_addr == REG_RESULT) ? {flow_buf, temp_buf}
		: (ph_addr == REG_STATUS) ? {13'h0, stop_busy, data_valid, running, stat_word}
		: (ph_addr == REG_LAST_CMD) ? {16'h0, cmd} : 32'h0;

	assign o_ahb = '{hrdata: hrdata, hreadyout: (!ph_rd || rd_out), hresp: 1'b0};

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			ph_wr   <= 1'b0;
			ph_rd   <= 1'b0;
			rd_out  <= 1'b0;
			ph_addr <= 32'h0;
			hrdata  <= 32'h0;
		end else if (i_hready) begin
			ph_wr   <= ahb_accept && i_ahb.hwrite;
			ph_rd   <= ahb_accept && !i_ahb.hwrite;
			ph_addr <= ahb_accept ? i_ahb.haddr : ph_addr;
			rd_out  <= 1'b0;
		end else if (ph_rd && !rd_out) begin
			hrdata <= rd_mux;
			rd_out <= 1'b1;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst || soft_rst) begin
			avg_fixed <= 1'b0;
		end else if (wr_now && ph_addr == REG_CTRL) begin
			avg_fixed <= i_ahb.hwdata[CTRL_FIXED_BIT];
		end
	end

	// Result buffers are fed by the measurement engine through the bus
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			flow_buf <= 16'h0000;
			temp_buf <= 16'h0000;
		end else if (wr_now && ph_addr == REG_RESULT) begin
			flow_buf <= i_ahb.hwdata[31:16];
			temp_buf <= i_ahb.hwdata[15:0];
		end
	end

endmodule // fmmp_top

//--- test/fmmp_asserts.sv
`timescale 1ns/1ns
module fmmp_asserts (
	input wire logic                    i_clk,
	input wire logic                    i_srst,
	input wire fmmp_pkg::fmmp_ahb_req_t i_ahb,
	input wire logic                    i_hready,
	input wire fmmp_pkg::fmmp_ahb_rsp_t o_ahb,
	input wire logic                    i_scl,
	input wire logic                    i_sda,
	input wire logic                    o_sda,
	input wire logic                    o_sda_oe_n
);
	import fmmp_pkg::*;
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_srst);
	////////////////////////////////////////////////////////////////////////
	sequence rd_taken;
		i_ahb.hsel && i_ahb.htrans[1] && !i_ahb.hwrite && i_hready;
	endsequence
	sequence wr_taken;
		i_ahb.hsel && i_ahb.htrans[1] && i_ahb.hwrite && i_hready;
	endsequence
	// One wait state, then the data stands
	sequence rd_done;
		!o_ahb.hreadyout ##1 o_ahb.hreadyout;
	endsequence
	////////////////////////////////////////////////////////////////////////
	hresp_okay_a: assert property (!o_ahb.hresp)
		else $error("hresp not OKAY");
	sda_low_a: assert property (o_sda == 1'h0)
		else $error("sda drive value not low");
	reset_idle_a: assert property ($fell(i_srst) |-> o_sda_oe_n && o_ahb.hreadyout)
		else $error("not idle after reset");
	// A move of SDA while SCL is high would read as START or STOP
	oe_scl_low_a: assert property ($changed(o_sda_oe_n) |-> !i_scl)
		else $error("sda enable moved while scl high");
	rd_wait_a: assert property (rd_taken |=> rd_done)
		else $error("read wait state wrong");
	one_wait_a: assert property (!o_ahb.hreadyout |=> o_ahb.hreadyout)
		else $error("wait state too long");
	wr_zero_a: assert property (wr_taken |=> o_ahb.hreadyout)
		else $error("write stalled");
	unmap_zero_a: assert property (rd_taken ##0 (i_ahb.haddr > REG_LAST_CMD)
		|=> rd_done ##0 (o_ahb.hrdata == 32'h0000_0000))
		else $error("unmapped read not zero");
	st_upper_a: assert property (rd_taken ##0 (i_ahb.haddr == REG_STATUS)
		|=> rd_done ##0 (o_ahb.hrdata[31:19] == 13'h0000))
		else $error("status upper bits set");
	// A STOP on the line must find the data line released right after
	stop_release_a: assert property (i_scl && $past(i_scl) && $rose(i_sda) |=> o_sda_oe_n)
		else $error("sda held after stop");
endmodule // fmmp_asserts

//--- test/fmmp_ctl_model.sv
`timescale 1ns/1ns
module fmmp_ctl_model #(
	parameter int HALF = 4
)(
	input  wire logic i_clk,
	input  wire logic i_sda,
	output logic      o_scl,
	output logic      o_sda_low
);
	// Clock stands high and data is released between frames
	initial begin
		o_scl = 1'h1;
		o_sda_low = 1'h0;
	end
	task automatic hb;
		repeat (HALF) @(posedge i_clk);
	endtask
	task automatic start;
		o_sda_low <= 1'h1;
		hb();
		o_scl <= 1'h0;
		hb();
	endtask
	task automatic stop;
		o_sda_low <= 1'h1;
		hb();
		o_scl <= 1'h1;
		hb();
		o_sda_low <= 1'h0;
		hb();
	endtask
	// Data moves one clock after SCL falls, never in the same sample
	task automatic put_bit(input logic b);
		@(posedge i_clk);
		o_sda_low <= !b;
		hb();
		o_scl <= 1'h1;
		hb();
		o_scl <= 1'h0;
	endtask
	task automatic get_bit(output logic b);
		@(posedge i_clk);
		o_sda_low <= 1'h0;
		hb();
		o_scl <= 1'h1;
		hb();
		b = i_sda;
		o_scl <= 1'h0;
	endtask
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic a;
		for (int i = 7; i >= 0; i--) put_bit(d[i]);
		get_bit(a);
		ack = !a;
	endtask
	task automatic rbyte(output logic [7:0] d, input logic last);
		for (int i = 7; i >= 0; i--) get_bit(d[i]);
		put_bit(last);
	endtask
endmodule // fmmp_ctl_model

//--- test/fmmp_top_tb.sv
`timescale 1ns/1ns
module fmmp_top_tb;
	import fmmp_pkg::*;
	// Short counts keep the run small
	localparam int unsigned FIRST = 400;
	localparam int unsigned SMOOTH = 2000;
	localparam int unsigned STOPC = 20;
	logic          i_clk = 1'h0;
	logic          i_srst = 1'h1;
	fmmp_ahb_req_t req = '0;
	fmmp_ahb_rsp_t rsp;
	logic          scl, ctl_low, oe_n, sda_o;
	wire           sda_w = !(ctl_low || (!oe_n && !sda_o));
	logic [7:0]    rb [9];
	int            err_count = 0;
	int            checks = 0;
	int            cyc = 0;
	always #10 i_clk = ~i_clk;
	fmmp_top #(.FIRST_CYCLES(FIRST), .SMOOTH_CYCLES(SMOOTH), .STOP_CYCLES(STOPC)) DUT (
		.i_clk(i_clk), .i_srst(i_srst), .i_ahb(req), .i_hready(rsp.hreadyout), .o_ahb(rsp),
		.i_scl(scl), .i_sda(sda_w), .o_sda(sda_o), .o_sda_oe_n(oe_n));
	fmmp_ctl_model m (.i_clk(i_clk), .i_sda(sda_w), .o_scl(scl), .o_sda_low(ctl_low));
	////////////////////////////////////////////////////////////////////////
	function automatic logic [7:0] crc8(input logic [15:0] d);
		logic [7:0] c;
		c = 8'hFF;
		for (int i = 15; i >= 0; i--) c = {c[6:0], 1'h0} ^ ((c[7] ^ d[i]) ? 8'h31 : 8'h00);
		return c;
	endfunction
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		checks++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic wrap_up;
		if (err_count == 0 && checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// Whole run needs about 60000 cycles
	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		if (cyc == 90000) begin
			err_count++;
			wrap_up();
		end
	end
	task automatic ahb(input logic w, input logic [31:0] a, wd, output logic [31:0] rd);
		req.hsel <= 1'h1;
		req.haddr <= a;
		req.htrans <= 2'h2;
		req.hwrite <= w;
		req.hsize <= 3'h2;
		do @(posedge i_clk); while (!rsp.hreadyout);
		req.htrans <= 2'h0;
		req.hwdata <= wd;
		do @(posedge i_clk); while (!rsp.hreadyout);
		rd = rsp.hrdata;
	endtask
	task automatic send(input logic [15:0] c, input int nb, input logic [15:0] a,
		input logic [7:0] cr, output logic ok);
		logic [7:0] by [6];
		logic ak;
		by = '{8'h5C, c[15:8], c[7:0], a[15:8], a[7:0], cr};
		m.start();
		for (int i = 0; i < nb; i++) begin
			m.wbyte(by[i], ak);
			if (i < nb - 1) chk("write ack", 16'h0001, {15'h0000, ak});
			ok = ak;
		end
		m.stop();
	endtask
	task automatic rd_chk(input logic eak, input int nb, input logic [15:0] w0, w1, w2);
		logic [15:0] e [3];
		logic ak;
		e = '{w0, w1, w2};
		m.start();
		m.wbyte(8'h5D, ak);
		chk("read ack", {15'h0000, eak}, {15'h0000, ak});
		if (ak) begin
			for (int i = 0; i < nb; i++) m.rbyte(rb[i], i == nb - 1);
			for (int k = 0; k < nb / 3; k++) begin
				chk("word", e[k], {rb[3 * k], rb[3 * k + 1]});
				chk("crc", {8'h00, crc8(e[k])}, {8'h00, rb[3 * k + 2]});
			end
		end
		m.stop();
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		logic [31:0] d;
		logic [15:0] conc, fl, tp, st;
		logic        ak, avg;
		void'($urandom(20005));
		repeat (4) @(posedge i_clk);
		i_srst <= 1'h0;
		@(posedge i_clk);
		ahb(1'h0, REG_STATUS, 32'h0, d);
		chk("avg default", 16'h0000, {15'h0000, d[ST_AVG_BIT]});
		ahb(1'h0, 32'h0000_0010, 32'h0, d);
		chk("unmapped", 16'h0000, d[15:0]);
		m.start();
		m.wbyte(8'h5E, ak);
		m.stop();
		chk("foreign addr", 16'h0000, {15'h0000, ak});
		rd_chk(1'h0, 0, 16'h0, 16'h0, 16'h0);
		for (int idx = 0; idx < 9; idx++) begin
			avg = 1'($urandom_range(1));
			conc = (idx == 6) ? 16'h03E8 : (idx > 6) ? 16'($urandom_range(1000)) : 16'h03FF;
			ahb(1'h1, REG_CTRL, {31'h0, avg}, d);
			if (idx >= 6) begin
				send(START_CODES[idx], 6, conc, crc8(conc) ^ 8'h01, ak);
				chk("bad crc ack", 16'h0000, {15'h0000, ak});
				rd_chk(1'h0, 0, 16'h0, 16'h0, 16'h0);
			end
			send(START_CODES[idx], (idx >= 6) ? 6 : 3, conc, crc8(conc), ak);
			chk("start ack", 16'h0001, {15'h0000, ak});
			rd_chk(1'h0, 0, 16'h0, 16'h0, 16'h0);
			repeat (FIRST) @(posedge i_clk);
			fl = 16'($urandom);
			tp = 16'($urandom);
			ahb(1'h1, REG_RESULT, {fl, tp}, d);
			st = {4'(idx), 1'h0, avg, conc[9:0]};
			rd_chk(1'h1, 9, fl, tp, st);
			rd_chk(1'h1, 3 * $urandom_range(1, 2), fl, tp, st);
			fl = 16'($urandom);
			tp = 16'($urandom);
			ahb(1'h1, REG_RESULT, {fl, tp}, d);
			repeat (SMOOTH + 50) @(posedge i_clk);
			st[ST_SMOOTH_BIT] = !avg;
			rd_chk(1'h1, 9, fl, tp, st);
			send(CMD_STOP, 3, 16'h0, 8'h00, ak);
			rd_chk(1'h0, 0, 16'h0, 16'h0, 16'h0);
			repeat (STOPC) @(posedge i_clk);
		end
		// Mixture start, live concentration update, then an update out of range
		ahb(1'h1, REG_CTRL, 32'h0, d);
		conc = 16'($urandom_range(1000));
		send(START_CODES[6], 6, 16'h01F4, crc8(16'h01F4), ak);
		repeat (FIRST) @(posedge i_clk);
		fl = 16'($urandom);
		tp = 16'($urandom);
		ahb(1'h1, REG_RESULT, {fl, tp}, d);
		ahb(1'h0, REG_STATUS, 32'h0, d);
		chk("run flags", 16'h0003, {13'h0000, d[18:16]});
		send(CMD_UPD_CONC, 6, conc, crc8(conc), ak);
		chk("update ack", 16'h0001, {15'h0000, ak});
		rd_chk(1'h1, 9, fl, tp, {4'h6, 2'h0, conc[9:0]});
		send(CMD_UPD_CONC, 6, 16'h03E9, crc8(16'h03E9), ak);
		chk("update stop ack", 16'h0001, {15'h0000, ak});
		rd_chk(1'h0, 0, 16'h0, 16'h0, 16'h0);
		ahb(1'h0, REG_LAST_CMD, 32'h0, d);
		chk("last command", CMD_UPD_CONC, d[15:0]);
		// Soft reset while running drops measurement and averaging choice
		ahb(1'h1, REG_CTRL, 32'h1, d);
		send(START_CODES[1], 3, 16'h0, 8'h00, ak);
		repeat (FIRST) @(posedge i_clk);
		ahb(1'h0, REG_STATUS, 32'h0, d);
		chk("avg fixed", 16'h0001, {15'h0000, d[ST_AVG_BIT]});
		send(CMD_SOFT_RESET, 3, 16'h0, 8'h00, ak);
		chk("soft reset ack", 16'h0001, {15'h0000, ak});
		rd_chk(1'h0, 0, 16'h0, 16'h0, 16'h0);
		ahb(1'h0, REG_STATUS, 32'h0, d);
		chk("soft reset status", 16'h03FF, d[15:0]);
		chk("soft reset flags", 16'h0000, {13'h0000, d[18:16]});
		// Hard reset in mid-run
		ahb(1'h1, REG_CTRL, 32'h1, d);
		send(START_CODES[0], 3, 16'h0, 8'h00, ak);
		i_srst <= 1'h1;
		repeat (2) @(posedge i_clk);
		i_srst <= 1'h0;
		@(posedge i_clk);
		ahb(1'h0, REG_STATUS, 32'h0, d);
		chk("reset status", 16'h03FF, d[15:0]);
		chk("reset flags", 16'h0000, {13'h0000, d[18:16]});
		rd_chk(1'h0, 0, 16'h0, 16'h0, 16'h0);
		wrap_up();
	end
endmodule // fmmp_top_tb
bind fmmp_top fmmp_asserts u_chk (
	.i_clk(i_clk), .i_srst(i_srst), .i_ahb(i_ahb), .i_hready(i_hready), .o_ahb(o_ahb),
	.i_scl(i_scl), .i_sda(i_sda), .o_sda(o_sda), .o_sda_oe_n(o_sda_oe_n));
